// ### rtl/sosc_pkg.sv
// Shared constants and types of the sixteen-output switch controller
package sosc_pkg;

    // Serial word shape
    localparam int WORD_BITS = 24;
    localparam int NUM_OUT = 16;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 18;
    localparam int CMD_BITS = 6;

    // Command codes in bits 23..18
    localparam logic [5:0] CMD_ON_OFF = 6'h00;
    localparam logic [5:0] CMD_OL_EN = 6'h01;
    localparam logic [5:0] CMD_RETRY = 6'h02;
    localparam logic [5:0] CMD_SFP_SEL = 6'h03;
    localparam logic [5:0] CMD_PWM_EN = 6'h04;
    localparam logic [5:0] CMD_COMBINE = 6'h05;
    localparam logic [5:0] CMD_RESET = 6'h06;

    // Field positions
    localparam int RETRY_OV_BIT = 16;
    localparam int RETRY_THERM_BIT = 17;
    localparam int RETRY_OV_IDX = 0;
    localparam int RETRY_THERM_IDX = 1;
    localparam int SO_ANY_BIT = 23;
    localparam int SO_OV_BIT = 22;
    localparam int SO_ZERO_BITS = 6;

    // Power-on values of the control registers
    localparam logic [15:0] ON_OFF_RST = 16'h0000;
    localparam logic [15:0] OL_EN_RST = 16'h0000;
    localparam logic [15:0] SFP_SEL_RST = 16'hffff;
    localparam logic [15:0] PWM_EN_RST = 16'h0000;
    localparam logic [15:0] COMBINE_RST = 16'h0000;
    localparam logic [1:0] RETRY_RST = 2'h0;

    // Overvoltage persistence time and its cycle count
    localparam int SYS_CLK_MHZ = 200;
    localparam int OV_FILTER_US = 50;
    localparam int OV_FILTER_CYCLES = OV_FILTER_US * SYS_CLK_MHZ;

    // Command queue depth
    localparam int CMD_FIFO_DEPTH = 4;

    // Command executor states
    typedef enum logic [0:0] {
        EX_IDLE = 1'b0,
        EX_APPLY = 1'b1
    } sosc_exec_t;

endpackage : sosc_pkg

// ### rtl/sosc_fifo.sv
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sosc_fifo #(
    parameter int P_WIDTH = 24,
    parameter int P_DEPTH = 4
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [P_WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [P_WIDTH-1:0] o_out_data
);
    localparam int AW = (P_DEPTH > 1) ? $clog2(P_DEPTH) : 1;
    localparam logic [AW:0] CNT_FULL = (AW+1)'(P_DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(P_DEPTH - 1);

    generate
        if (P_DEPTH < 2) begin : g_bad_depth
            $error("sosc_fifo depth must be at least 2");
        end
    endgenerate

    logic [P_WIDTH-1:0] mem_r [P_DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // Honest flags straight from the occupancy count
    assign o_in_ready = (count_r != CNT_FULL);
    assign o_out_valid = (count_r != '0);
    assign o_out_data = mem_r[rd_ptr_r];

    // Pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; empty entries are never read out
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

endmodule : sosc_fifo

// ### rtl/sosc_core.sv
// Serial command interpreter and control registers of the sixteen-output switch
`timescale 1ns/100ps
module sosc_core
    import sosc_pkg::*;
#(
    parameter int P_OV_FILTER_CYCLES = OV_FILTER_CYCLES,
    parameter int P_FIFO_DEPTH = CMD_FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_por,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_pwm,
    input wire logic i_ov_detect,
    input wire logic [15:0] i_thermal_fault,
    input wire logic [15:0] i_overcurrent_fault,
    input wire logic [15:0] i_open_load_detect,
    output logic o_so,
    output logic o_so_oe,
    output logic [15:0] o_switch_outputs,
    output logic [15:0] o_open_load_current_enable,
    output logic [15:0] o_short_fault_protect_select,
    output logic o_cmd_ready
);
    localparam int OVW = $clog2(P_OV_FILTER_CYCLES + 1);
    localparam logic [OVW-1:0] OV_LIMIT = OVW'(P_OV_FILTER_CYCLES);
    localparam int SYNC_W = 6 + 3 * NUM_OUT;
    localparam logic [4:0] BIT_LAST = 5'(WORD_BITS - 1);

    generate
        if (P_OV_FILTER_CYCLES < 1) begin : g_bad_filter
            $error("sosc_core overvoltage filter needs at least one cycle");
        end
        if (P_FIFO_DEPTH < 2) begin : g_bad_fifo
            $error("sosc_core command queue needs at least two entries");
        end
    endgenerate

    // Command code compare, shared by every register decode
    function automatic logic sosc_hit(input logic [WORD_BITS-1:0] w, input logic [5:0] code);
        return w[CMD_MSB:CMD_LSB] == code;
    endfunction : sosc_hit

    // ---- Input synchronisers ----
    logic [SYNC_W-1:0] sync_a_r;
    logic [SYNC_W-1:0] sync_b_r;
    wire [SYNC_W-1:0] sync_in = {i_por, i_sclk, i_cs_n, i_si, i_pwm, i_ov_detect,
                                 i_thermal_fault, i_overcurrent_fault, i_open_load_detect};
    localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, 1'b0, 1'b1, {(SYNC_W-3){1'b0}}};

    // Two flops on every pin; stage a feeds stage b only
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sync_a_r <= SYNC_RST;
            sync_b_r <= SYNC_RST;
        end else begin
            sync_a_r <= sync_in;
            sync_b_r <= sync_a_r;
        end
    end

    wire por_s = sync_b_r[SYNC_W-1];
    wire sclk_s = sync_b_r[SYNC_W-2];
    wire cs_n_s = sync_b_r[SYNC_W-3];
    wire si_s = sync_b_r[SYNC_W-4];
    wire pwm_s = sync_b_r[SYNC_W-5];
    wire ov_s = sync_b_r[SYNC_W-6];
    wire [15:0] therm_s = sync_b_r[3*NUM_OUT-1:2*NUM_OUT];
    wire [15:0] oc_s = sync_b_r[2*NUM_OUT-1:NUM_OUT];
    wire [15:0] ol_s = sync_b_r[NUM_OUT-1:0];

    // Reset pin holds the whole block; supply reset holds all but the synchronisers and edge detectors
    wire hard_rst = !i_rst_n || por_s;

    // ---- Edge detection on the serial pins ----
    logic sclk_d_r;
    logic cs_n_d_r;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // Clock edges count only inside a frame; the host parks the clock low at select edges
    wire cs_fall = cs_n_d_r && !cs_n_s;
    wire cs_rise = !cs_n_d_r && cs_n_s;
    wire sclk_rise = !sclk_d_r && sclk_s && !cs_n_s;
    wire sclk_fall = sclk_d_r && !sclk_s && !cs_n_s;

    // ---- Fault capture ----
    logic [15:0] on_off_r;
    logic [15:0] ol_en_r;
    logic [15:0] pwm_en_r;
    logic [15:0] combine_r;
    logic [15:0] sfp_sel_r;
    logic [1:0] retry_r;
    logic [15:0] therm_lock_r;
    logic [15:0] fault_lat_r;
    logic ov_flag_r;
    logic ov_shut_r;
    logic [OVW-1:0] ov_cnt_r;
    logic [15:0] drive_cmd;
    logic [15:0] fault_now;
    logic cmd_rst;

    // Per-output drive request and live fault
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            // PWM pin combined with the on/off bit only where enabled
            assign drive_cmd[gi] = !pwm_en_r[gi] ? on_off_r[gi] :
                                   combine_r[gi] ? (on_off_r[gi] || pwm_s) :
                                                   (on_off_r[gi] && pwm_s);
            // Off-state open load needs its pull-down current on
            assign fault_now[gi] = therm_s[gi] || oc_s[gi] ||
                                   (ol_s[gi] && ol_en_r[gi] && !drive_cmd[gi]);
        end
    endgenerate

    // Faults latch until the next frame closes; a fault in that cycle survives
    wire [15:0] fault_lat_nxt = (cs_rise ? 16'h0000 : fault_lat_r) | fault_now;
    wire ov_flag_nxt = (cs_rise ? 1'b0 : ov_flag_r) || ov_shut_r;
    wire any_fault = (|(fault_lat_r | fault_now)) || ov_flag_r || ov_shut_r;
    wire [WORD_BITS-1:0] status_word = {any_fault, ov_flag_r || ov_shut_r,
                                        {SO_ZERO_BITS{1'b0}}, fault_lat_r | fault_now};

    always_ff @(posedge i_sys_clk) begin
        if (hard_rst || cmd_rst) begin
            fault_lat_r <= 16'h0000;
            ov_flag_r <= 1'b0;
        end else begin
            fault_lat_r <= fault_lat_nxt;
            ov_flag_r <= ov_flag_nxt;
        end
    end

    // ---- Serial shift register ----
    logic [WORD_BITS-1:0] shift_r;
    logic [4:0] bit_cnt_r;
    logic got_clk_r;
    logic so_r;
    logic so_oe_r;

    // One register serves both directions, so input bits emerge 24 clocks later
    always_ff @(posedge i_sys_clk) begin
        if (hard_rst) begin
            shift_r <= '0;
        end else if (cs_fall) begin
            shift_r <= status_word;
        end else if (sclk_fall) begin
            shift_r <= {shift_r[WORD_BITS-2:0], si_s};
        end
    end

    // Bit count modulo one word, so daisy-chained multiples still pass
    always_ff @(posedge i_sys_clk) begin
        if (hard_rst || cs_fall) begin
            bit_cnt_r <= 5'h00;
            got_clk_r <= 1'b0;
        end else if (sclk_fall) begin
            bit_cnt_r <= (bit_cnt_r == BIT_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
            got_clk_r <= 1'b1;
        end
    end

    // Data out changes on clock rise; driver enabled only while selected
    always_ff @(posedge i_sys_clk) begin
        if (hard_rst) begin
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= !cs_n_s;
            if (cs_fall) begin
                so_r <= 1'b0;
            end else if (sclk_rise) begin
                so_r <= shift_r[WORD_BITS-1];
            end
        end
    end

    // ---- Command queue ----
    // Words are queued at select rise, never decoded mid-shift
    wire frame_ok = got_clk_r && (bit_cnt_r == 5'h00);
    wire push_word = cs_rise && frame_ok;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [WORD_BITS-1:0] fifo_out_data;
    sosc_exec_t ex_state_r;
    sosc_exec_t ex_state_nxt;
    wire pop_word = fifo_out_valid && (ex_state_r == EX_IDLE);

    sosc_fifo #(
        .P_WIDTH(WORD_BITS),
        .P_DEPTH(P_FIFO_DEPTH)
    ) u_cmd_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(!hard_rst),
        .i_in_valid(push_word),
        .o_in_ready(fifo_in_ready),
        .i_in_data(shift_r),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(ex_state_r == EX_IDLE),
        .o_out_data(fifo_out_data)
    );

    // ---- Command executor ----
    logic [WORD_BITS-1:0] cmd_r;

    // Pop in idle, apply next cycle; two cycles per word, far shorter than a frame, so the queue never holds more than one word
    always_comb begin
        ex_state_nxt = ex_state_r;
        unique case (ex_state_r)
            EX_IDLE: begin
                if (pop_word) begin
                    ex_state_nxt = EX_APPLY;
                end
            end
            EX_APPLY: begin
                ex_state_nxt = EX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (hard_rst) begin
            ex_state_r <= EX_IDLE;
            cmd_r <= '0;
        end else begin
            ex_state_r <= ex_state_nxt;
            if (pop_word) begin
                cmd_r <= fifo_out_data;
            end
        end
    end

    // Decode strobes; unknown codes match nothing and change nothing
    wire apply = (ex_state_r == EX_APPLY);
    wire wr_on_off = apply && sosc_hit(cmd_r, CMD_ON_OFF);
    wire wr_ol_en = apply && sosc_hit(cmd_r, CMD_OL_EN);
    wire wr_retry = apply && sosc_hit(cmd_r, CMD_RETRY);
    wire wr_sfp = apply && sosc_hit(cmd_r, CMD_SFP_SEL);
    wire wr_pwm = apply && sosc_hit(cmd_r, CMD_PWM_EN);
    wire wr_comb = apply && sosc_hit(cmd_r, CMD_COMBINE);
    assign cmd_rst = apply && sosc_hit(cmd_r, CMD_RESET);
    wire [15:0] cmd_data = cmd_r[NUM_OUT-1:0];
    wire [1:0] cmd_retry = {cmd_r[RETRY_THERM_BIT], cmd_r[RETRY_OV_BIT]};
    wire ctl_rst = hard_rst || cmd_rst;

    // ---- Overvoltage filter ----
    // Counter restarts whenever the detector lets go, so glitches never add up
    always_ff @(posedge i_sys_clk) begin
        if (hard_rst || !ov_s) begin
            ov_cnt_r <= '0;
        end else if (ov_cnt_r != OV_LIMIT) begin
            ov_cnt_r <= ov_cnt_r + 1'b1;
        end
    end

    // Shutdown holds from the limit until the detector clears
    wire ov_shut_nxt = ov_s && (ov_shut_r || (ov_cnt_r == OV_LIMIT));
    wire ov_recover = ov_shut_r && !ov_s;
    always_ff @(posedge i_sys_clk) begin
        if (hard_rst) begin
            ov_shut_r <= 1'b0;
        end else begin
            ov_shut_r <= ov_shut_nxt;
        end
    end

    // ---- Control registers ----
    // On/off; recovery without retry drops every stored on bit
    always_ff @(posedge i_sys_clk) begin
        if (ctl_rst) begin
            on_off_r <= ON_OFF_RST;
        end else if (wr_on_off) begin
            on_off_r <= cmd_data;
        end else if (ov_recover && !retry_r[RETRY_OV_IDX]) begin
            on_off_r <= 16'h0000;
        end
    end

    // Each register changes only on its own command
    always_ff @(posedge i_sys_clk) begin
        if (ctl_rst) begin
            ol_en_r <= OL_EN_RST;
            retry_r <= RETRY_RST;
            sfp_sel_r <= SFP_SEL_RST;
            pwm_en_r <= PWM_EN_RST;
            combine_r <= COMBINE_RST;
        end else begin
            ol_en_r <= wr_ol_en ? cmd_data : ol_en_r;
            retry_r <= wr_retry ? cmd_retry : retry_r;
            sfp_sel_r <= wr_sfp ? cmd_data : sfp_sel_r;
            pwm_en_r <= wr_pwm ? cmd_data : pwm_en_r;
            combine_r <= wr_comb ? cmd_data : combine_r;
        end
    end

    // Thermal lock: retry releases on cooling, else only a cleared on/off bit does
    wire [15:0] therm_release = retry_r[RETRY_THERM_IDX] ? ~therm_s : ~on_off_r;
    wire [15:0] therm_lock_nxt = (therm_lock_r & ~therm_release) | therm_s;
    always_ff @(posedge i_sys_clk) begin
        if (ctl_rst) begin
            therm_lock_r <= 16'h0000;
        end else begin
            therm_lock_r <= therm_lock_nxt;
        end
    end

    // ---- Outputs ----
    // Thermal limit always cuts an output at once, before the lock has caught it
    wire [15:0] out_nxt = drive_cmd & ~therm_s & ~therm_lock_r & {NUM_OUT{!ov_shut_r}};

    always_ff @(posedge i_sys_clk) begin
        if (hard_rst) begin
            o_switch_outputs <= 16'h0000;
            o_open_load_current_enable <= OL_EN_RST;
            o_short_fault_protect_select <= SFP_SEL_RST;
            o_cmd_ready <= 1'b0;
        end else begin
            o_switch_outputs <= out_nxt;
            o_open_load_current_enable <= ol_en_r;
            o_short_fault_protect_select <= sfp_sel_r;
            o_cmd_ready <= fifo_in_ready;
        end
    end

    assign o_so = so_r;
    assign o_so_oe = so_oe_r;

endmodule : sosc_core

// ### dv/sosc_core_asserts.sv
// Port-level property checker for the switch controller core
`timescale 1ns/100ps
module sosc_core_asserts #(
    parameter int P_OV_FILTER_CYCLES = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_por,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_ov_detect,
    input wire logic [15:0] i_thermal_fault,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic [15:0] o_switch_outputs,
    input wire logic [15:0] o_open_load_current_enable,
    input wire logic [15:0] o_short_fault_protect_select
);
    int ov_cnt;

    // Length of the present overvoltage episode; too long for a repetition
    always_ff @(posedge i_sys_clk) begin
        ov_cnt <= (i_ov_detect && i_rst_n) ? ov_cnt + 1 : 0;
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Serial output driver follows the select line, with sync slack
    AST_SO_HIZ: assert property (i_cs_n [*6] |-> !o_so_oe)
        else $error("serial output driven while deselected");
    AST_SO_DRIVE: assert property (!i_cs_n [*6] |-> o_so_oe)
        else $error("serial output not driven while selected");
    // Output data moves only after a rising serial clock
    AST_SO_HOLD: assert property ((!i_sclk && !i_cs_n) [*8] |-> $stable(o_so))
        else $error("serial output moved while clock low");
    // Registers change only after the frame closes
    AST_CMD_AT_CLOSE: assert property (!i_cs_n [*8] |->
        $stable(o_open_load_current_enable) && $stable(o_short_fault_protect_select))
        else $error("register changed in mid frame");
    // Supply reset and reset pin force power-on values
    AST_POR_OFF: assert property (i_por [*6] |-> o_switch_outputs == 16'h0000
        && o_open_load_current_enable == 16'h0000 && o_short_fault_protect_select == 16'hffff)
        else $error("supply reset did not clear state");
    AST_RST_VALUES: assert property ($rose(i_rst_n) |-> o_switch_outputs == 16'h0000
        && o_open_load_current_enable == 16'h0000 && o_short_fault_protect_select == 16'hffff)
        else $error("reset pin did not clear state");
    // Long overvoltage cuts every output
    AST_OV_SHUT: assert property (ov_cnt >= P_OV_FILTER_CYCLES + 6 |-> o_switch_outputs == 16'h0000)
        else $error("outputs on during overvoltage");
    // A steady thermal fault cuts its own output
    AST_THERM_CUT: assert property ((i_thermal_fault != 16'h0000 && $stable(i_thermal_fault)) [*6]
        |-> (o_switch_outputs & i_thermal_fault) == 16'h0000)
        else $error("output on during thermal fault");
endmodule : sosc_core_asserts

// ### dv/sosc_host_model.sv
// Host-side serial master for the switch controller link
`timescale 1ns/100ps
module sosc_host_model (
    input wire logic i_sys_clk,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    // Idle link: clock low, deselected
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : wt

    // One frame of n bits, MSB first; 80 ns clock phases
    task automatic xfer(input logic [47:0] d, input int n, output logic [47:0] q);
        q = 48'h0000_0000_0000;
        o_cs_n <= 1'b0;
        wt(24);
        for (int i = n - 1; i >= 0; i--) begin
            o_si <= d[i];
            o_sclk <= 1'b1;
            wt(16);
            q[i] = i_so;
            o_sclk <= 1'b0;
            wt(16);
        end
        wt(8);
        o_cs_n <= 1'b1;
        o_si <= ~o_si; // Released line must not keep the last bit
        wt(24);
    endtask : xfer
endmodule : sosc_host_model

// ### dv/spi_sixteen_output_switch_control_bench.sv
// Self-checking bench for the switch controller core over its serial link
`timescale 1ns/100ps
bind sosc_core sosc_core_asserts #(.P_OV_FILTER_CYCLES(P_OV_FILTER_CYCLES)) chk_u (.i_sys_clk, .i_rst_n,
    .i_por, .i_sclk, .i_cs_n, .i_ov_detect, .i_thermal_fault, .o_so, .o_so_oe, .o_switch_outputs,
    .o_open_load_current_enable, .o_short_fault_protect_select);

module spi_sixteen_output_switch_control_bench import sosc_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic por = 1'b0;
    logic pwm = 1'b0;
    logic ov = 1'b0;
    logic [15:0] therm = 16'h0000;
    logic [15:0] ocf = 16'h0000;
    logic [15:0] old = 16'h0000;
    logic sclk, cs_n, si, so, so_oe;
    logic [15:0] sw, olce, sfp;
    logic rdy;
    logic [47:0] q;
    wire so_line;
    int fail_count = 0;
    int samples_checked = 0;

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    // Tri-state serial output as seen by the host
    assign so_line = so_oe ? so : 1'bz;

    sosc_core #(.P_OV_FILTER_CYCLES(20), .P_FIFO_DEPTH(4)) dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_por(por), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_pwm(pwm), .i_ov_detect(ov),
        .i_thermal_fault(therm), .i_overcurrent_fault(ocf), .i_open_load_detect(old), .o_so(so),
        .o_so_oe(so_oe), .o_switch_outputs(sw), .o_open_load_current_enable(olce),
        .o_short_fault_protect_select(sfp), .o_cmd_ready(rdy));

    sosc_host_model host_u (.i_sys_clk(sys_clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));

    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt

    task wrap_up;
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Pins after the command pipeline has settled
    task chk_pins(input logic [15:0] e_sw, input logic [15:0] e_ol, input logic [15:0] e_sfp);
        wt(12);
        chk("switch_outputs", {8'h00, e_sw}, {8'h00, sw});
        chk("open_load_current_enable", {8'h00, e_ol}, {8'h00, olce});
        chk("short_fault_protect_select", {8'h00, e_sfp}, {8'h00, sfp});
    endtask : chk_pins

    task cmd(input logic [5:0] c, input logic [17:0] d);
        host_u.xfer({24'h00_0000, c, d}, 24, q);
    endtask : cmd

    // Hang guard, about three times the expected run
    initial begin
        wt(60000);
        fail_count++;
        wrap_up;
    end

    initial begin
        wt(4);
        rst_n <= 1'b1;
        wt(8);
        chk_pins(16'h0000, 16'h0000, 16'hffff);
        chk("so_oe", 24'h00_0000, {23'h00_0000, so_oe});
        chk("cmd_ready", 24'h00_0001, {23'h00_0000, rdy});
        cmd(CMD_ON_OFF, 18'h3_a5c5);
        chk_pins(16'ha5c5, 16'h0000, 16'hffff);
        cmd(CMD_OL_EN, 18'h0_00ff);
        cmd(CMD_SFP_SEL, 18'h0_1234);
        chk_pins(16'ha5c5, 16'h00ff, 16'h1234);
        host_u.xfer({24'h00_0000, CMD_OL_EN, 18'h0_0000}, 23, q);
        chk_pins(16'ha5c5, 16'h00ff, 16'h1234);
        host_u.xfer({6'h07, 18'h0_0000, CMD_SFP_SEL, 18'h0_5678}, 48, q);
        chk("chained_word", 24'h1c_0000, q[23:0]);
        chk("first_status", 24'h00_0000, q[47:24]);
        chk_pins(16'ha5c5, 16'h00ff, 16'h5678);
        // Overcurrent on 5, open load on 1 (current on) and 8 (current off)
        ocf <= 16'h0020;
        old <= 16'h0102;
        wt(8);
        cmd(6'h07, 18'h0_0000);
        chk("status", 24'h80_0022, q[23:0]);
        ocf <= 16'h0000;
        old <= 16'h0000;
        cmd(6'h07, 18'h0_0000);
        chk("status", 24'h80_0022, q[23:0]);
        cmd(6'h07, 18'h0_0000);
        chk("status", 24'h00_0000, q[23:0]);
        // Overvoltage with resume, then with stay-off
        cmd(CMD_RETRY, 18'h1_0000);
        ov <= 1'b1;
        wt(10);
        ov <= 1'b0;
        chk_pins(16'ha5c5, 16'h00ff, 16'h5678);
        ov <= 1'b1;
        wt(40);
        chk_pins(16'h0000, 16'h00ff, 16'h5678);
        cmd(6'h07, 18'h0_0000);
        chk("status", 24'hc0_0000, q[23:0]);
        ov <= 1'b0;
        chk_pins(16'ha5c5, 16'h00ff, 16'h5678);
        cmd(CMD_RETRY, 18'h0_0000);
        ov <= 1'b1;
        wt(40);
        ov <= 1'b0;
        chk_pins(16'h0000, 16'h00ff, 16'h5678);
        // Thermal with retry, then without
        cmd(CMD_ON_OFF, 18'h0_a5c5);
        cmd(CMD_RETRY, 18'h2_0000);
        therm <= 16'h0005;
        chk_pins(16'ha5c0, 16'h00ff, 16'h5678);
        therm <= 16'h0000;
        chk_pins(16'ha5c5, 16'h00ff, 16'h5678);
        cmd(CMD_RETRY, 18'h0_0000);
        therm <= 16'h0001;
        wt(8);
        therm <= 16'h0000;
        chk_pins(16'ha5c4, 16'h00ff, 16'h5678);
        // Pulse pin: OR on outputs 0 and 1, AND on 2 and 3
        cmd(CMD_ON_OFF, 18'h0_a5c4);
        cmd(CMD_PWM_EN, 18'h0_000f);
        cmd(CMD_COMBINE, 18'h0_0003);
        chk_pins(16'ha5c0, 16'h00ff, 16'h5678);
        pwm <= 1'b1;
        chk_pins(16'ha5c7, 16'h00ff, 16'h5678);
        cmd(CMD_RESET, 18'h3_ffff);
        chk_pins(16'h0000, 16'h0000, 16'hffff);
        // Supply reset, then reset pin, each in mid-run; state is set first so the clear shows
        cmd(CMD_ON_OFF, 18'h0_00ff);
        chk_pins(16'h00ff, 16'h0000, 16'hffff);
        por <= 1'b1;
        chk_pins(16'h0000, 16'h0000, 16'hffff);
        chk("cmd_ready", 24'h00_0000, {23'h00_0000, rdy});
        por <= 1'b0;
        wt(8);
        cmd(CMD_SFP_SEL, 18'h0_0000);
        chk_pins(16'h0000, 16'h0000, 16'h0000);
        rst_n <= 1'b0;
        chk_pins(16'h0000, 16'h0000, 16'hffff);
        chk("cmd_ready", 24'h00_0000, {23'h00_0000, rdy});
        rst_n <= 1'b1;
        wt(8);
        chk("cmd_ready", 24'h00_0001, {23'h00_0000, rdy});
        wrap_up;
    end
endmodule : spi_sixteen_output_switch_control_bench
